// >>> common/angle_defs.svh
`ifndef ANGLE_DEFS_SVH
`define ANGLE_DEFS_SVH

// serial commands, top three bits of a frame
`define CMD_READ_ANGLE   3'h0
`define CMD_READ_REG     3'h2
`define CMD_WRITE_REG    3'h4

// frame layout
`define FRAME_BITS       16
`define FRM_CMD_MSB      15
`define FRM_CMD_LSB      13
`define FRM_ADDR_MSB     12
`define FRM_ADDR_LSB     8
`define FRM_DATA_MSB     7
`define FRM_DATA_LSB     0

// register addresses
`define REG_ZERO_LO      5'h00
`define REG_ZERO_HI      5'h01
`define REG_BIAS_TRIM    5'h02
`define REG_TRIM_EN      5'h03
`define REG_FIELD_THR    5'h06
`define REG_DIRECTION    5'h09
`define REG_FIELD_FLAGS  5'h1b

// field positions
`define TRIM_X_BIT       0
`define TRIM_Y_BIT       1
`define LOW_THR_MSB      7
`define LOW_THR_LSB      5
`define HIGH_THR_MSB     4
`define HIGH_THR_LSB     2
`define DETECT_EN_BIT    0
`define DIRECTION_BIT    7
`define FLAG_HIGH_BIT    7
`define FLAG_LOW_BIT     6

// reset values
`define RST_ZERO         16'h0000
`define RST_BYTE         8'h00
`define RST_FIELD_THR    8'h1d

// field detector, millitesla
`define FIELD_HYST_MT    6
`define THR0_RISE_MT     8'h1a
`define THR1_RISE_MT     8'h29
`define THR2_RISE_MT     8'h38
`define THR3_RISE_MT     8'h46
`define THR4_RISE_MT     8'h54
`define THR5_RISE_MT     8'h62
`define THR6_RISE_MT     8'h70
`define THR7_RISE_MT     8'h7e

`endif

// >>> common/angle_pkg.sv
package angle_pkg;
   typedef enum logic [1:0] {
      RESP_ANGLE = 2'b01,
      RESP_REG   = 2'b10
   } resp_t;
   typedef logic [7:0]  reg_byte_t;
   typedef logic [15:0] angle_word_t;
endpackage

// >>> hw/angle_sensor_config.sv
`timescale 1ns/1ps
`include "angle_defs.svh"
// Overview of operation
// - output angle is raw minus zero offset; with direction set, minus raw minus zero
// - zero code step is one 65536th turn
// - direction bit selects clockwise or counterclockwise increase
// - eight bit bias trim amount, 0 to 255
// - each axis enable gates trim onto axis
// - both enables trim both axes equally
// - field measurement runs only when enabled
// - three bit thresholds in register 6
// - low threshold above high is accepted
// - 6 mT hysteresis on both flags
// - flags in register 27, low on pin
// - read data returned in the next frame
module angle_sensor_config
   import angle_pkg::*;
#(
   parameter int FIELD_W = 8
)(
   input  wire logic               i_clk,
   input  wire logic               i_nrst,
   input  wire logic               i_sclk,
   input  wire logic               i_csn,
   input  wire logic               i_mosi,
   input  wire angle_word_t        i_raw_angle,
   input  wire logic [FIELD_W-1:0] i_field_mt,
   output logic                    o_miso,
   output angle_word_t             o_angle,
   output reg_byte_t               o_bias_trim_x,
   output reg_byte_t               o_bias_trim_y,
   output logic                    o_field_detect_enable,
   output logic                    o_field_low_pin
);
   angle_word_t rx_word;
   logic        rx_toggle;
   angle_word_t tx_word;
   angle_word_t next_tx_word;

   logic [2:0]  tog_sync;
   logic [2:0]  next_tog_sync;
   logic [2:0]  csn_sync;
   logic [2:0]  next_csn_sync;
   logic        tog_acc;
   logic        next_tog_acc;
   logic        csn_idle;
   logic        next_csn_idle;
   logic        frame_evt;

   angle_word_t zero;
   angle_word_t next_zero;
   reg_byte_t   bias_trim;
   reg_byte_t   next_bias_trim;
   logic [1:0]  trim_en;
   logic [1:0]  next_trim_en;
   logic [2:0]  low_thr;
   logic [2:0]  next_low_thr;
   logic [2:0]  high_thr;
   logic [2:0]  next_high_thr;
   logic        detect_en;
   logic        next_detect_en;
   logic        direction;
   logic        next_direction;
   resp_t       resp_kind;
   resp_t       next_resp_kind;
   logic [4:0]  resp_addr;
   logic [4:0]  next_resp_addr;

   angle_word_t next_angle;
   reg_byte_t   next_trim_x;
   reg_byte_t   next_trim_y;
   logic        low_flag;
   logic        high_flag;
   reg_byte_t   rd_byte;

   logic [2:0]  cmd;
   logic [4:0]  addr;
   reg_byte_t   wdata;

   assign cmd   = rx_word[`FRM_CMD_MSB:`FRM_CMD_LSB];
   assign addr  = rx_word[`FRM_ADDR_MSB:`FRM_ADDR_LSB];
   assign wdata = rx_word[`FRM_DATA_MSB:`FRM_DATA_LSB];

   spi_link u_link (
      .i_sclk      (i_sclk),
      .i_nrst      (i_nrst),
      .i_csn       (i_csn),
      .i_mosi      (i_mosi),
      .i_tx_word   (tx_word),
      .o_miso      (o_miso),
      .o_rx_word   (rx_word),
      .o_rx_toggle (rx_toggle)
   );

   field_detector #(
      .FIELD_W (FIELD_W)
   ) u_field (
      .i_clk       (i_clk),
      .i_nrst      (i_nrst),
      .i_enable    (detect_en),
      .i_low_code  (low_thr),
      .i_high_code (high_thr),
      .i_field_mt  (i_field_mt),
      .o_low_flag  (low_flag),
      .o_high_flag (high_flag)
   );

   // unused bits of the flag byte are don't-care; they read as zero here
   function automatic reg_byte_t read_reg(input logic [4:0] a);
      reg_byte_t v;
      v = `RST_BYTE;
      case (a)
         `REG_ZERO_LO:     v = zero[7:0];
         `REG_ZERO_HI:     v = zero[15:8];
         `REG_BIAS_TRIM:   v = bias_trim;
         `REG_TRIM_EN:     v = {6'h00, trim_en};
         `REG_FIELD_THR:   v = {low_thr, high_thr, 1'b0, detect_en};
         `REG_DIRECTION:   v = {direction, 7'h00};
         `REG_FIELD_FLAGS: v = {high_flag, low_flag, 6'h00};
         default:          v = `RST_BYTE;
      endcase
      return v;
   endfunction

   assign rd_byte = read_reg(resp_addr);

   // frame-done toggle and select cross on three flops; a change counts once
   // the second and third agree
   always_comb
   begin
      next_tog_sync = {tog_sync[1:0], rx_toggle};
      next_csn_sync = {csn_sync[1:0], i_csn};
      frame_evt     = (tog_sync[1] == tog_sync[2]) && (tog_sync[2] != tog_acc);
      next_tog_acc  = frame_evt ? tog_sync[2] : tog_acc;
      next_csn_idle = (csn_sync[1] == csn_sync[2]) ? csn_sync[2] : csn_idle;
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         tog_sync <= 3'h0;
         csn_sync <= 3'h7;
         tog_acc  <= 1'b0;
         csn_idle <= 1'b1;
      end
      else
      begin
         tog_sync <= next_tog_sync;
         csn_sync <= next_csn_sync;
         tog_acc  <= next_tog_acc;
         csn_idle <= next_csn_idle;
      end
   end

   // one step of zero is 360/65536 degrees, code 0 is zero degrees
   always_comb
   begin
      next_zero      = zero;
      next_bias_trim = bias_trim;
      next_trim_en   = trim_en;
      next_low_thr   = low_thr;
      next_high_thr  = high_thr;
      next_detect_en = detect_en;
      next_direction = direction;
      next_resp_kind = resp_kind;
      next_resp_addr = resp_addr;
      if (frame_evt)
      begin
         next_resp_kind = RESP_ANGLE;
         if (cmd == `CMD_READ_REG || cmd == `CMD_WRITE_REG)
         begin
            next_resp_kind = RESP_REG;
            next_resp_addr = addr;
         end
         if (cmd == `CMD_WRITE_REG)
         begin
            case (addr)
               `REG_ZERO_LO:   next_zero[7:0]  = wdata;
               `REG_ZERO_HI:   next_zero[15:8] = wdata;
               `REG_BIAS_TRIM: next_bias_trim  = wdata;
               `REG_TRIM_EN:   next_trim_en    = {wdata[`TRIM_Y_BIT], wdata[`TRIM_X_BIT]};
               `REG_FIELD_THR:
               begin
                  next_low_thr   = wdata[`LOW_THR_MSB:`LOW_THR_LSB];
                  next_high_thr  = wdata[`HIGH_THR_MSB:`HIGH_THR_LSB];
                  next_detect_en = wdata[`DETECT_EN_BIT];
               end
               `REG_DIRECTION: next_direction  = wdata[`DIRECTION_BIT];
               default:        next_zero       = zero;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         zero      <= `RST_ZERO;
         bias_trim <= `RST_BYTE;
         trim_en   <= 2'h0;
         low_thr   <= 3'(`RST_FIELD_THR >> `LOW_THR_LSB);
         high_thr  <= 3'(`RST_FIELD_THR >> `HIGH_THR_LSB);
         detect_en <= 1'(`RST_FIELD_THR >> `DETECT_EN_BIT);
         direction <= 1'b0;
         resp_kind <= RESP_ANGLE;
         resp_addr <= 5'h00;
      end
      else
      begin
         zero      <= next_zero;
         bias_trim <= next_bias_trim;
         trim_en   <= next_trim_en;
         low_thr   <= next_low_thr;
         high_thr  <= next_high_thr;
         detect_en <= next_detect_en;
         direction <= next_direction;
         resp_kind <= next_resp_kind;
         resp_addr <= next_resp_addr;
      end
   end

   // the transmit word is refreshed only while the synced select is high; select
   // takes up to four clocks to cross, so an angle that moves in the first clocks
   // of a frame can still reach the link: keep the raw angle steady around frames
   always_comb
   begin
      if (direction)
         next_angle = 16'(16'h0000 - i_raw_angle - zero);
      else
         next_angle = 16'(i_raw_angle - zero);
      next_trim_x = trim_en[`TRIM_X_BIT] ? bias_trim : `RST_BYTE;
      next_trim_y = trim_en[`TRIM_Y_BIT] ? bias_trim : `RST_BYTE;
      next_tx_word = tx_word;
      if (csn_idle)
      begin
         if (resp_kind == RESP_REG)
            next_tx_word = {o_angle[15:8], rd_byte};
         else
            next_tx_word = o_angle;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_angle               <= 16'h0000;
         o_bias_trim_x         <= `RST_BYTE;
         o_bias_trim_y         <= `RST_BYTE;
         o_field_detect_enable <= 1'b0;
         tx_word               <= 16'h0000;
      end
      else
      begin
         o_angle               <= next_angle;
         o_bias_trim_x         <= next_trim_x;
         o_bias_trim_y         <= next_trim_y;
         o_field_detect_enable <= detect_en;
         tx_word               <= next_tx_word;
      end
   end

   assign o_field_low_pin = low_flag;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   zero_sub_a: assert property (
      !direction && $stable(zero) |=> o_angle == 16'($past(i_raw_angle) - $past(zero)))
      else $error("angle is not raw minus zero");
   angle_wrap_a: assert property (
      !direction && $stable(zero) && i_raw_angle < zero |=> o_angle > 16'hffff - $past(zero))
      else $error("angle did not wrap around one turn");
   ccw_dir_a: assert property (
      direction && $stable(zero) |=> o_angle == 16'(16'h0000 - $past(i_raw_angle) - $past(zero)))
      else $error("counterclockwise angle wrong");
   trim_x_a: assert property (
      !trim_en[`TRIM_X_BIT] ##1 !trim_en[`TRIM_X_BIT] |-> o_bias_trim_x == 8'h00)
      else $error("x trim applied while disabled");
   trim_both_a: assert property (
      trim_en == 2'h3 && $stable(bias_trim) |=> o_bias_trim_x == $past(bias_trim) && o_bias_trim_y == $past(bias_trim))
      else $error("trim not equal on both axes");
   det_off_a: assert property (
      !detect_en |=> !low_flag && !high_flag && !o_field_detect_enable)
      else $error("field flags active while detection disabled");
   thr_store_a: assert property (
      frame_evt && cmd == `CMD_WRITE_REG && addr == `REG_FIELD_THR
      |=> low_thr == rx_word[`LOW_THR_MSB:`LOW_THR_LSB] && high_thr == rx_word[`HIGH_THR_MSB:`HIGH_THR_LSB])
      else $error("threshold write not stored");
   flag_reg_a: assert property (
      csn_idle && resp_kind == RESP_REG && resp_addr == `REG_FIELD_FLAGS
      |=> tx_word[7:6] == $past({high_flag, o_field_low_pin}))
      else $error("flag byte does not match flags and pin");
   resp_next_a: assert property (
      frame_evt && cmd == `CMD_READ_REG |=> resp_kind == RESP_REG && resp_addr == addr)
      else $error("read command did not arm a register reply");
   tx_load_a: assert property (
      csn_idle && resp_kind == RESP_REG |=> tx_word[7:0] == $past(rd_byte))
      else $error("reply word does not carry register value");

   read_c: cover property (frame_evt && cmd == `CMD_READ_REG && addr == `REG_FIELD_FLAGS);
   write_c: cover property (frame_evt && cmd == `CMD_WRITE_REG && addr == `REG_ZERO_HI);
   ccw_c: cover property ($rose(direction));
   high_c: cover property ($rose(high_flag));
endmodule

// >>> hw/field_detector.sv
`timescale 1ns/1ps
`include "angle_defs.svh"
module field_detector
   import angle_pkg::*;
#(
   parameter int FIELD_W = 8
)(
   input  wire logic               i_clk,
   input  wire logic               i_nrst,
   input  wire logic               i_enable,
   input  wire logic [2:0]         i_low_code,
   input  wire logic [2:0]         i_high_code,
   input  wire logic [FIELD_W-1:0] i_field_mt,
   output logic                    o_low_flag,
   output logic                    o_high_flag
);
   logic next_low;
   logic next_high;

   function automatic logic [FIELD_W-1:0] rise_mt(input logic [2:0] code);
      logic [7:0] v;
      v = `THR0_RISE_MT;
      unique case (code)
         3'h0: v = `THR0_RISE_MT;
         3'h1: v = `THR1_RISE_MT;
         3'h2: v = `THR2_RISE_MT;
         3'h3: v = `THR3_RISE_MT;
         3'h4: v = `THR4_RISE_MT;
         3'h5: v = `THR5_RISE_MT;
         3'h6: v = `THR6_RISE_MT;
         3'h7: v = `THR7_RISE_MT;
      endcase
      return FIELD_W'(v);
   endfunction

   function automatic logic [FIELD_W-1:0] fall_mt(input logic [2:0] code);
      return FIELD_W'(rise_mt(code) - FIELD_W'(`FIELD_HYST_MT));
   endfunction

   // codes are compared independently, so low above high is legal
   always_comb
   begin
      next_low  = o_low_flag;
      next_high = o_high_flag;
      if (!i_enable)
      begin
         next_low  = 1'b0;
         next_high = 1'b0;
      end
      else
      begin
         if (i_field_mt < fall_mt(i_low_code))
            next_low = 1'b1;
         else if (i_field_mt >= rise_mt(i_low_code))
            next_low = 1'b0;
         if (i_field_mt >= rise_mt(i_high_code))
            next_high = 1'b1;
         else if (i_field_mt < fall_mt(i_high_code))
            next_high = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_low_flag  <= 1'b0;
         o_high_flag <= 1'b0;
      end
      else
      begin
         o_low_flag  <= next_low;
         o_high_flag <= next_high;
      end
   end

   high_rise_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_enable && i_field_mt >= rise_mt(i_high_code) |=> o_high_flag)
      else $error("high flag not raised at rising threshold");
   low_hyst_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_low_flag && i_enable && i_field_mt >= fall_mt(i_low_code) && i_field_mt < rise_mt(i_low_code)
      |=> o_low_flag)
      else $error("low flag dropped inside hysteresis band");
   low_set_c: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_low_flag));
endmodule

// >>> hw/spi_link.sv
`timescale 1ns/1ps
`include "angle_defs.svh"
module spi_link
   import angle_pkg::*;
(
   input  wire logic        i_sclk,
   input  wire logic        i_nrst,
   input  wire logic        i_csn,
   input  wire logic        i_mosi,
   input  wire angle_word_t i_tx_word,
   output logic             o_miso,
   output angle_word_t      o_rx_word,
   output logic             o_rx_toggle
);
   // clock idles low, data launched on rising and sampled on falling edge;
   // the bit counter is cleared by the frame select itself, since sclk stops
   logic        link_rst_n;
   logic [3:0]  bit_cnt;
   logic [3:0]  next_bit_cnt;
   logic [14:0] shift;
   logic [14:0] next_shift;
   angle_word_t next_rx_word;
   logic        next_rx_toggle;
   logic        next_miso;

   assign link_rst_n = i_nrst & ~i_csn;

   always_comb
   begin
      next_bit_cnt   = bit_cnt + 4'h1;
      next_shift     = {shift[13:0], i_mosi};
      next_rx_word   = o_rx_word;
      next_rx_toggle = o_rx_toggle;
      if (bit_cnt == 4'(`FRAME_BITS - 1))
      begin
         next_rx_word   = {shift, i_mosi};
         next_rx_toggle = ~o_rx_toggle;
      end
      // i_tx_word is only changed by the core while its synced copy of select is high, up to four clocks into a frame
      next_miso = i_tx_word[4'(`FRAME_BITS - 1) - bit_cnt];
   end

   always_ff @(negedge i_sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         bit_cnt <= 4'h0;
         shift   <= 15'h0000;
      end
      else
      begin
         bit_cnt <= next_bit_cnt;
         shift   <= next_shift;
      end
   end

   always_ff @(negedge i_sclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_rx_word   <= 16'h0000;
         o_rx_toggle <= 1'b0;
      end
      else
      begin
         o_rx_word   <= next_rx_word;
         o_rx_toggle <= next_rx_toggle;
      end
   end

   always_ff @(posedge i_sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
         o_miso <= 1'b0;
      else
         o_miso <= next_miso;
   end
endmodule

// >>> tb/spi_ctrl_model.sv
`timescale 1ns/1ps
module spi_ctrl_model
(
   input  wire logic i_clk,
   input  wire logic i_miso,
   output logic      o_sclk,
   output logic      o_csn,
   output logic      o_mosi
);
   // link clock runs only inside frames, 64 ns period
   localparam int HALF_NS = 32;

   initial
   begin
      o_sclk = 1'b0;
      o_csn  = 1'b1;
      o_mosi = 1'b0;
   end

   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      int i;
      @(posedge i_clk);
      o_csn <= 1'b0;
      #(HALF_NS + 7);
      for (i = 15; i >= 0; i--)
      begin
         o_sclk = 1'b1;
         o_mosi <= tx[i];
         #(HALF_NS);
         o_sclk = 1'b0;
         rx[i] = i_miso;
         #(HALF_NS);
      end
      @(posedge i_clk);
      o_csn  <= 1'b1;
      o_mosi <= ~o_mosi;
      // the core needs five cycles with select high to arm the reply; twelve are waited
      repeat (12) @(posedge i_clk);
   endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "angle_defs.svh"
module testbench
   import angle_pkg::*;
;
   logic        i_clk;
   logic        i_nrst;
   logic        sclk;
   logic        csn;
   logic        mosi;
   logic        miso;
   angle_word_t i_raw_angle;
   logic [7:0]  i_field_mt;
   angle_word_t o_angle;
   reg_byte_t   o_bias_trim_x;
   reg_byte_t   o_bias_trim_y;
   logic        o_field_detect_enable;
   logic        o_field_low_pin;
   int          bad_count;
   int          n_checks;
   logic [15:0] rx;
   logic [7:0]  thr_rise [8] = '{8'h1a, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7e};

   angle_sensor_config #(.FIELD_W(8)) u_angle_sensor_config (
      .i_clk                 (i_clk),
      .i_nrst                (i_nrst),
      .i_sclk                (sclk),
      .i_csn                 (csn),
      .i_mosi                (mosi),
      .i_raw_angle           (i_raw_angle),
      .i_field_mt            (i_field_mt),
      .o_miso                (miso),
      .o_angle               (o_angle),
      .o_bias_trim_x         (o_bias_trim_x),
      .o_bias_trim_y         (o_bias_trim_y),
      .o_field_detect_enable (o_field_detect_enable),
      .o_field_low_pin       (o_field_low_pin)
   );

   spi_ctrl_model u_spi_ctrl_model (
      .i_clk  (i_clk),
      .i_miso (miso),
      .o_sclk (sclk),
      .o_csn  (csn),
      .o_mosi (mosi)
   );

   always #25 i_clk = ~i_clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      u_spi_ctrl_model.xfer({`CMD_WRITE_REG, a, d}, rx);
   endtask

   // the reply only arrives in the frame after the command
   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      u_spi_ctrl_model.xfer({`CMD_READ_REG, a, 8'h00}, rx);
      u_spi_ctrl_model.xfer({`CMD_READ_ANGLE, 13'h0000}, rx);
      v = rx[7:0];
   endtask

   task automatic drive(input logic [15:0] raw, input logic [7:0] fld);
      @(posedge i_clk);
      i_raw_angle <= raw;
      i_field_mt  <= fld;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   task automatic flags(input logic hi, input logic lo);
      logic [7:0] v;
      rd(`REG_FIELD_FLAGS, v);
      chk(v, {hi, lo, 6'h00});
      chk(o_field_low_pin, lo);
   endtask

   task automatic t_reset;
      logic [7:0] v;
      logic [4:0] zero_regs [5] = '{`REG_ZERO_LO, `REG_ZERO_HI, `REG_BIAS_TRIM, `REG_TRIM_EN, `REG_DIRECTION};
      chk(o_field_detect_enable, 1'b1);
      chk(miso, 1'b0);
      rd(`REG_FIELD_THR, v);
      chk(v, 8'h1d);
      foreach (zero_regs[k])
      begin
         rd(zero_regs[k], v);
         chk(v, 8'h00);
      end
   endtask

   task automatic t_zero;
      wr(`REG_ZERO_LO, 8'h34);
      wr(`REG_ZERO_HI, 8'h12);
      drive(16'h0010, 8'h50);
      chk(o_angle, 16'heddc);
      u_spi_ctrl_model.xfer(16'h0000, rx);
      u_spi_ctrl_model.xfer(16'h0000, rx);
      chk(rx, 16'heddc);
      wr(`REG_ZERO_LO, 8'hff);
      wr(`REG_ZERO_HI, 8'hff);
      drive(16'h0000, 8'h50);
      chk(o_angle, 16'h0001);
      wr(`REG_ZERO_LO, 8'h00);
      wr(`REG_ZERO_HI, 8'h00);
   endtask

   task automatic t_dir;
      wr(`REG_DIRECTION, 8'h80);
      drive(16'h0100, 8'h50);
      chk(o_angle, 16'hff00);
      drive(16'h0101, 8'h50);
      chk(o_angle, 16'hfeff);
      wr(`REG_DIRECTION, 8'h00);
      drive(16'h0101, 8'h50);
      chk(o_angle, 16'h0101);
   endtask

   task automatic t_trim;
      logic [7:0] v;
      logic [1:0] en;
      wr(`REG_BIAS_TRIM, 8'hff);
      for (int e = 0; e < 4; e++)
      begin
         en = 2'(e);
         wr(`REG_TRIM_EN, {6'h00, en});
         chk(o_bias_trim_x, en[0] ? 8'hff : 8'h00);
         chk(o_bias_trim_y, en[1] ? 8'hff : 8'h00);
      end
      rd(`REG_BIAS_TRIM, v);
      chk(v, 8'hff);
      wr(`REG_BIAS_TRIM, 8'h00);
      chk(o_bias_trim_x, 8'h00);
   endtask

   // each code is walked through both edges of both hysteresis bands
   task automatic t_field;
      logic [7:0] r;
      logic [7:0] f;
      logic [7:0] fs [5];
      logic       hs [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      logic       ls [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int c = 0; c < 8; c++)
      begin
         wr(`REG_FIELD_THR, {3'(c), 3'(c), 2'b01});
         r  = thr_rise[c];
         f  = r - 8'h06;
         fs = '{r, f, f - 8'h01, r - 8'h01, r};
         for (int s = 0; s < 5; s++)
         begin
            drive(16'h0101, fs[s]);
            flags(hs[s], ls[s]);
         end
      end
   endtask

   task automatic t_cross;
      logic [7:0] v;
      wr(`REG_FIELD_THR, 8'he1);
      drive(16'h0101, 8'h3c);
      flags(1'b1, 1'b1);
      rd(`REG_FIELD_THR, v);
      chk(v, 8'he1);
   endtask

   task automatic t_disable;
      wr(`REG_FIELD_THR, 8'he0);
      chk(o_field_detect_enable, 1'b0);
      drive(16'h0101, 8'h3c);
      flags(1'b0, 1'b0);
      wr(`REG_FIELD_THR, 8'he1);
      chk(o_field_detect_enable, 1'b1);
   endtask

   task automatic t_pipe;
      logic [7:0] v;
      wr(`REG_BIAS_TRIM, 8'h5a);
      u_spi_ctrl_model.xfer({`CMD_READ_REG, `REG_FIELD_FLAGS, 8'h00}, rx);
      chk(rx, 16'h015a);
      u_spi_ctrl_model.xfer({`CMD_READ_ANGLE, 13'h0000}, rx);
      chk(rx, 16'h01c0);
      wr(`REG_FIELD_FLAGS, 8'h00);
      wr(5'h05, 8'haa);
      rd(5'h05, v);
      chk(v, 8'h00);
      flags(1'b1, 1'b1);
   endtask

   initial
   begin
      i_clk       = 1'b0;
      i_nrst      = 1'b0;
      i_raw_angle = 16'h0000;
      i_field_mt  = 8'h50;
      bad_count   = 0;
      n_checks    = 0;
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (10) @(posedge i_clk);
      @(negedge i_clk);
      t_reset();
      t_zero();
      t_dir();
      t_trim();
      t_field();
      t_cross();
      t_disable();
      t_pipe();
      end_sim();
   end

   // about 250 us of traffic expected
   initial
   begin
      #(2_000_000);
      bad_count++;
      end_sim();
   end
endmodule
